// File: psrd_board_model.sv
module psrd_board_model (
  // clock
  input wire logic core_clk_in,
  // board strapping, bits are {code[4:0], low data bit0, grant4}
  input wire logic [6:0] strap_val_in,
  input wire logic [6:0] strap_fit_in,
  // device side of the pins
  input wire logic pullup_en_in,
  input wire logic grant4_drv_in,
  input wire logic grant4_oe_in,
  output logic [4:0] strap_cfg_out,
  output logic low_data_bit0_out,
  output logic bus_grant4_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic float_reg = 1'b0;
  logic [6:0] pin_lvl;

  // ------------------------------------------------------------
  // pin levels
  // ------------------------------------------------------------
  // an open pin with no pull-up shows noise, not a held level
  always_ff @(posedge core_clk_in)
  begin
    float_reg <= ~float_reg;
  end

  always_comb
  begin
    for (int i = 0; i < 7; i++)
    begin
      pin_lvl[i] = strap_fit_in[i] ? strap_val_in[i] : (pullup_en_in ? 1'b1 : float_reg);
    end
  end

  assign strap_cfg_out = pin_lvl[6:2];
  assign low_data_bit0_out = pin_lvl[1];
  // device driver overrides the weak strap resistor
  assign bus_grant4_out = grant4_oe_in ? grant4_drv_in : pin_lvl[0];
endmodule // psrd_board_model

// File: psrd_pkg.sv
// Notes on behaviour
// - both clock ratios come from the five-bit configuration strap alone.
// - each listed strap code maps to a fixed pair of multipliers.
// - processor multiplier code follows the processor ratio, except ratio 2 reads 00100 under codes 10000 and 10010 and 00101 otherwise.
// - codes 00011, 00101, 00111 select bypass; processor ratio stays 2, 2.5, 3.
// - bypass clocks processor from reference, memory PLL off, ratio 1:1.
// - codes 11110 and 11111 stop all internal clocking.
// - readback code is shared by several straps; it identifies the strap only for codes 01010, 10100, 11110 and 11111.
// - reset-only pull-ups make an unstrapped pin sample as one.
// - low data bit zero pin is a reset configuration input, default one.
// - bus grant four pin is a reset configuration input, default one.
// - designated outputs drive by default, open-drain when power control asks.
// - sustained three-state pin is driven high one cycle before release.
package psrd_pkg;

  // ---------------------------------------------------------------
  // widths and constants
  // ---------------------------------------------------------------
  localparam int CFG_W = 5;
  localparam int RB_W = 5;
  localparam int DBG_W = 5;
  localparam logic [3:0] BYPASS_MEM_X2 = 4'h2;
  localparam logic PULLUP_RST = 1'b1;

  // ratios are held doubled so that half steps stay integers
  typedef struct packed {
    logic [3:0] mem_x2;
    logic [3:0] cpu_x2;
    logic [RB_W-1:0] readback;
    logic bypass;
    logic clk_off;
    logic invalid;
  } psrd_ratio_s;

  typedef enum logic [1:0] {
    STRI_IDLE = 2'h0,
    STRI_DRIVE = 2'h1,
    STRI_PARK = 2'h3
  } psrd_stri_e;

  typedef struct packed {
    logic captured;
    logic pullup_en;
    logic [CFG_W-1:0] cfg;
    logic dl0_cfg;
    logic bus_grant4_strap_cfg;
    psrd_ratio_s ratio;
    logic mem_clk_en;
    logic mem_pll_en;
    logic cpu_clk_en;
    logic cpu_src_ref;
    logic bus_grant4_strap_out;
    logic bus_grant4_strap_oe;
    logic od_out;
    logic od_oe;
    psrd_stri_e stri_st;
    logic stri_out;
    logic stri_oe;
    logic [DBG_W-1:0] dbg_addr;
    logic dbg_bit2;
  } psrd_state_s;

  function automatic psrd_ratio_s psrd_row(input logic [3:0] m, input logic [3:0] c,
                                           input logic [4:0] rb, input logic byp,
                                           input logic off, input logic inv);
    psrd_ratio_s r;
    r.mem_x2 = m;
    r.cpu_x2 = c;
    r.readback = rb;
    r.bypass = byp;
    r.clk_off = off;
    r.invalid = inv;
    return r;
  endfunction

  // strap code written left to right is msb to lsb
  function automatic psrd_ratio_s psrd_decode(input logic [CFG_W-1:0] code);
    psrd_ratio_s r;
    r = psrd_row(4'h0, 4'h0, 5'h00, 1'b0, 1'b0, 1'b1);
    case (code)
      5'h00: r = psrd_row(4'h6, 4'h5, 5'h06, 1'b0, 1'b0, 1'b0);
      5'h01: r = psrd_row(4'h6, 4'h6, 5'h18, 1'b0, 1'b0, 1'b1);
      5'h02: r = psrd_row(4'h2, 4'h4, 5'h05, 1'b0, 1'b0, 1'b0);
      5'h03: r = psrd_row(BYPASS_MEM_X2, 4'h4, 5'h05, 1'b1, 1'b0, 1'b0);
      5'h04: r = psrd_row(4'h4, 4'h4, 5'h05, 1'b0, 1'b0, 1'b0);
      5'h05: r = psrd_row(BYPASS_MEM_X2, 4'h5, 5'h06, 1'b1, 1'b0, 1'b0);
      5'h07: r = psrd_row(BYPASS_MEM_X2, 4'h6, 5'h18, 1'b1, 1'b0, 1'b0);
      5'h08: r = psrd_row(4'h2, 4'h6, 5'h18, 1'b0, 1'b0, 1'b0);
      5'h0A: r = psrd_row(4'h4, 4'h9, 5'h07, 1'b0, 1'b0, 1'b1);
      5'h0C: r = psrd_row(4'h4, 4'h5, 5'h06, 1'b0, 1'b0, 1'b0);
      5'h0E: r = psrd_row(4'h4, 4'h6, 5'h18, 1'b0, 1'b0, 1'b0);
      5'h10: r = psrd_row(4'h6, 4'h4, 5'h04, 1'b0, 1'b0, 1'b0);
      5'h12: r = psrd_row(4'h3, 4'h4, 5'h04, 1'b0, 1'b0, 1'b0);
      5'h14: r = psrd_row(4'h4, 4'h7, 5'h1E, 1'b0, 1'b0, 1'b0);
      5'h16: r = psrd_row(4'h4, 4'h8, 5'h1A, 1'b0, 1'b0, 1'b0);
      5'h18: r = psrd_row(4'h5, 4'h6, 5'h18, 1'b0, 1'b0, 1'b0);
      5'h1A: r = psrd_row(4'h2, 4'h8, 5'h1A, 1'b0, 1'b0, 1'b0);
      5'h1C: r = psrd_row(4'h3, 4'h6, 5'h18, 1'b0, 1'b0, 1'b0);
      5'h1D: r = psrd_row(4'h3, 4'h5, 5'h06, 1'b0, 1'b0, 1'b0);
      5'h1E: r = psrd_row(4'h0, 4'h0, 5'h0F, 1'b0, 1'b1, 1'b0);
      5'h1F: r = psrd_row(4'h0, 4'h0, 5'h1F, 1'b0, 1'b1, 1'b0);
      default: r = psrd_row(4'h0, 4'h0, 5'h00, 1'b0, 1'b0, 1'b1);
    endcase
    return r;
  endfunction

endpackage

// File: psrd_tb.sv
`define CHK(got, exp) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) \
    begin \
      fail_count++; \
      $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  int fail_count = 0;
  int tests_run = 0;
  logic core_clk_in = 1'b0, reset_n_in = 1'b0, bus_grant4_in = 1'b0;
  logic power_mgmt_control_two_od_in = 1'b0, od_pin_data_in = 1'b0;
  logic stri_drive_in = 1'b0, stri_data_in = 1'b0, debug_en_in = 1'b0;
  logic debug_bit_two_in = 1'b0;
  logic [4:0] debug_addr_in = 5'h00;
  logic [6:0] strap_val = 7'h00, strap_fit = 7'h00;
  logic [4:0] pin_cfg, debug_address_out, strap_cfg_out, cpu_multiplier_readback_out;
  logic pin_dl0, pin_bus_grant4_strap, bus_grant4_out, bus_grant4_oe_out, od_pin_out, od_pin_oe_out;
  logic stri_pin_out, stri_pin_oe_out, debug_address_bit_two_out, pullup_en_out;
  logic cfg_valid_out, low_data_bit0_cfg_out, bus_grant4_cfg_out, bypass_out;
  logic clock_off_out, invalid_out, mem_clk_en_out, mem_pll_en_out, cpu_clk_en_out;
  logic cpu_src_ref_out;
  logic [3:0] mem_mult_x2_out, cpu_mult_x2_out;
  // per code: {mem x2, cpu x2, readback, bypass, off, invalid}
  localparam logic [15:0] dec_tbl [32] = '{
    16'h6530, 16'h66C1, 16'h2428, 16'h242C, 16'h4428, 16'h2534, 16'h0001, 16'h26C4,
    16'h26C0, 16'h0001, 16'h4939, 16'h0001, 16'h4530, 16'h0001, 16'h46C0, 16'h0001,
    16'h6420, 16'h0001, 16'h3420, 16'h0001, 16'h47F0, 16'h0001, 16'h48D0, 16'h0001,
    16'h56C0, 16'h0001, 16'h28D0, 16'h0001, 16'h36C0, 16'h3530, 16'h007A, 16'h00FA};

  // ------------------------------------------------------------
  // board and device
  // ------------------------------------------------------------
  psrd_board_model board (.core_clk_in, .strap_val_in(strap_val), .strap_fit_in(strap_fit),
    .pullup_en_in(pullup_en_out), .grant4_drv_in(bus_grant4_out),
    .grant4_oe_in(bus_grant4_oe_out), .strap_cfg_out(pin_cfg),
    .low_data_bit0_out(pin_dl0), .bus_grant4_out(pin_bus_grant4_strap));
  // debug address outputs go nowhere on this board
  psrd_top dut (.core_clk_in, .reset_n_in, .strap_cfg_in(pin_cfg),
    .low_data_bit0_strap_in(pin_dl0), .bus_grant4_strap_in(pin_bus_grant4_strap), .bus_grant4_in,
    .bus_grant4_out, .bus_grant4_oe_out, .power_mgmt_control_two_od_in, .od_pin_data_in,
    .od_pin_out, .od_pin_oe_out, .stri_drive_in, .stri_data_in, .stri_pin_out,
    .stri_pin_oe_out, .debug_en_in, .debug_addr_in, .debug_bit_two_in, .debug_address_out,
    .debug_address_bit_two_out, .pullup_en_out, .cfg_valid_out, .strap_cfg_out,
    .low_data_bit0_cfg_out, .bus_grant4_cfg_out, .mem_mult_x2_out, .cpu_mult_x2_out,
    .cpu_multiplier_readback_out, .bypass_out, .clock_off_out, .invalid_out,
    .mem_clk_en_out, .mem_pll_en_out, .cpu_clk_en_out, .cpu_src_ref_out);

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic do_reset(input logic [6:0] val, input logic [6:0] fit);
    strap_val = val;
    strap_fit = fit;
    reset_n_in = 1'b0;
    repeat (3) @(posedge core_clk_in);
    #1;
    `CHK({pullup_en_out, bus_grant4_oe_out, cfg_valid_out}, 3'h4)
    reset_n_in = 1'b1;
    @(posedge core_clk_in);
    #1;
    `CHK({pullup_en_out, cfg_valid_out}, 2'h1)
  endtask

  task automatic t_pullup;
    do_reset(7'h00, 7'h00);
    `CHK(strap_cfg_out, 5'h1F)
    `CHK({low_data_bit0_cfg_out, bus_grant4_cfg_out}, 2'h3)
    `CHK({clock_off_out, mem_clk_en_out, cpu_clk_en_out}, 3'h4)
    $display("test t_pullup finished");
  endtask

  task automatic t_decode;
    logic [15:0] w;
    logic en;
    for (int c = 0; c < 32; c++)
    begin
      w = dec_tbl[c];
      en = ~w[1] & ~w[0];
      // reserved codes are strapped on purpose to see them refused
      do_reset({c[4:0], c[0], ~c[0]}, 7'h7F);
      `CHK(strap_cfg_out, c[4:0])
      `CHK({low_data_bit0_cfg_out, bus_grant4_cfg_out}, {c[0], ~c[0]})
      `CHK({mem_mult_x2_out, cpu_mult_x2_out}, w[15:8])
      `CHK(cpu_multiplier_readback_out, w[7:3])
      `CHK({bypass_out, clock_off_out, invalid_out}, w[2:0])
      `CHK({mem_clk_en_out, cpu_clk_en_out}, {en, en})
      `CHK({mem_pll_en_out, cpu_src_ref_out}, {en & ~w[2], en & w[2]})
      strap_val = ~strap_val;
      repeat (2) @(posedge core_clk_in);
      #1;
      `CHK({strap_cfg_out, mem_mult_x2_out, cpu_mult_x2_out}, {c[4:0], w[15:8]})
    end
    $display("test t_decode finished");
  endtask

  task automatic t_od;
    for (int i = 0; i < 4; i++)
    begin
      power_mgmt_control_two_od_in = i[1];
      od_pin_data_in = i[0];
      @(posedge core_clk_in);
      #1;
      `CHK({od_pin_out, od_pin_oe_out}, i[1] ? {1'b0, ~i[0]} : {i[0], 1'b1})
    end
    $display("test t_od finished");
  endtask

  task automatic t_stri;
    stri_drive_in = 1'b1;
    stri_data_in = 1'b0;
    @(posedge core_clk_in);
    #1;
    `CHK({stri_pin_oe_out, stri_pin_out}, 2'h2)
    stri_data_in = 1'b1;
    @(posedge core_clk_in);
    #1;
    `CHK({stri_pin_oe_out, stri_pin_out}, 2'h3)
    stri_drive_in = 1'b0;
    stri_data_in = 1'b0;
    @(posedge core_clk_in);
    #1;
    `CHK({stri_pin_oe_out, stri_pin_out}, 2'h3)
    @(posedge core_clk_in);
    #1;
    `CHK(stri_pin_oe_out, 1'b0)
    $display("test t_stri finished");
  endtask

  task automatic t_pass;
    debug_en_in = 1'b1;
    debug_addr_in = 5'h15;
    debug_bit_two_in = 1'b1;
    @(posedge core_clk_in);
    #1;
    `CHK({debug_address_out, debug_address_bit_two_out}, 6'h2B)
    `CHK({bus_grant4_out, bus_grant4_oe_out}, 2'h1)
    debug_en_in = 1'b0;
    bus_grant4_in = 1'b1;
    @(posedge core_clk_in);
    #1;
    `CHK({debug_address_out, debug_address_bit_two_out}, 6'h00)
    `CHK({bus_grant4_out, bus_grant4_oe_out}, 2'h3)
    $display("test t_pass finished");
  endtask

  // ------------------------------------------------------------
  // clock, sequence, watchdog
  // ------------------------------------------------------------
  initial
  begin
    forever #2.5 core_clk_in = ~core_clk_in;
  end

  initial
  begin
    t_pullup;
    t_decode;
    t_od;
    t_stri;
    t_pass;
    report_and_stop;
  end

  // about 200 cycles expected; allow ample margin
  initial
  begin
    #20000;
    fail_count++;
    report_and_stop;
  end
endmodule // testbench

// File: psrd_top.sv
module psrd_top (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  // reset configuration pins, input side
  input wire logic [psrd_pkg::CFG_W-1:0] strap_cfg_in,
  input wire logic low_data_bit0_strap_in,
  input wire logic bus_grant4_strap_in,
  // bus grant four, normal output function
  input wire logic bus_grant4_in,
  output logic bus_grant4_out,
  output logic bus_grant4_oe_out,
  // push-pull or open-drain output
  input wire logic power_mgmt_control_two_od_in,
  input wire logic od_pin_data_in,
  output logic od_pin_out,
  output logic od_pin_oe_out,
  // sustained three-state pin
  input wire logic stri_drive_in,
  input wire logic stri_data_in,
  output logic stri_pin_out,
  output logic stri_pin_oe_out,
  // debug address outputs
  input wire logic debug_en_in,
  input wire logic [psrd_pkg::DBG_W-1:0] debug_addr_in,
  input wire logic debug_bit_two_in,
  output logic [psrd_pkg::DBG_W-1:0] debug_address_out,
  output logic debug_address_bit_two_out,
  // configuration results
  output logic pullup_en_out,
  output logic cfg_valid_out,
  output logic [psrd_pkg::CFG_W-1:0] strap_cfg_out,
  output logic low_data_bit0_cfg_out,
  output logic bus_grant4_cfg_out,
  output logic [3:0] mem_mult_x2_out,
  output logic [3:0] cpu_mult_x2_out,
  output logic [psrd_pkg::RB_W-1:0] cpu_multiplier_readback_out,
  output logic bypass_out,
  output logic clock_off_out,
  output logic invalid_out,
  output logic mem_clk_en_out,
  output logic mem_pll_en_out,
  output logic cpu_clk_en_out,
  output logic cpu_src_ref_out
);

  psrd_pkg::psrd_state_s state_reg;
  psrd_pkg::psrd_state_s state_next;
  logic usable;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    usable = 1'b0;
    // first edge after release catches the straps, then they freeze
    if (!state_reg.captured)
    begin
      state_next.captured = 1'b1;
      state_next.pullup_en = 1'b0;
      state_next.cfg = strap_cfg_in;
      state_next.dl0_cfg = low_data_bit0_strap_in;
      state_next.bus_grant4_strap_cfg = bus_grant4_strap_in;
    end
    // readback follows the processor ratio, except codes 10000 and 10010 read 00100 for ratio 2
    state_next.ratio = psrd_pkg::psrd_decode(state_next.cfg);
    usable = state_next.captured && !state_next.ratio.clk_off
             && !state_next.ratio.invalid;
    state_next.mem_clk_en = usable;
    state_next.cpu_clk_en = usable;
    state_next.mem_pll_en = usable && !state_next.ratio.bypass;
    state_next.cpu_src_ref = usable && state_next.ratio.bypass;
    // grant pin stays released until its strap is taken
    state_next.bus_grant4_strap_oe = state_next.captured;
    state_next.bus_grant4_strap_out = state_next.captured && bus_grant4_in;
    if (power_mgmt_control_two_od_in)
    begin
      state_next.od_out = 1'b0;
      state_next.od_oe = !od_pin_data_in;
    end
    else
    begin
      state_next.od_out = od_pin_data_in;
      state_next.od_oe = 1'b1;
    end
    // park phase avoids a slow pull-up edge after release
    unique case (state_reg.stri_st)
      psrd_pkg::STRI_IDLE:
      begin
        if (stri_drive_in)
          state_next.stri_st = psrd_pkg::STRI_DRIVE;
      end
      psrd_pkg::STRI_DRIVE:
      begin
        if (!stri_drive_in)
          state_next.stri_st = psrd_pkg::STRI_PARK;
      end
      psrd_pkg::STRI_PARK:
        state_next.stri_st = psrd_pkg::STRI_IDLE;
      default:
        state_next.stri_st = psrd_pkg::STRI_IDLE;
    endcase
    state_next.stri_oe = (state_next.stri_st != psrd_pkg::STRI_IDLE);
    state_next.stri_out = (state_next.stri_st == psrd_pkg::STRI_DRIVE) ? stri_data_in :
                          (state_next.stri_st == psrd_pkg::STRI_PARK);
    // debug outputs idle low so an open pin carries nothing
    state_next.dbg_addr = debug_en_in ? debug_addr_in : '0;
    state_next.dbg_bit2 = debug_en_in && debug_bit_two_in;
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      state_reg <= '0;
      state_reg.pullup_en <= psrd_pkg::PULLUP_RST;
    end
    else
      state_reg <= state_next;
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign bus_grant4_out = state_reg.bus_grant4_strap_out;
  assign bus_grant4_oe_out = state_reg.bus_grant4_strap_oe;
  assign od_pin_out = state_reg.od_out;
  assign od_pin_oe_out = state_reg.od_oe;
  assign stri_pin_out = state_reg.stri_out;
  assign stri_pin_oe_out = state_reg.stri_oe;
  assign debug_address_out = state_reg.dbg_addr;
  assign debug_address_bit_two_out = state_reg.dbg_bit2;
  assign pullup_en_out = state_reg.pullup_en;
  assign cfg_valid_out = state_reg.captured;
  assign strap_cfg_out = state_reg.cfg;
  assign low_data_bit0_cfg_out = state_reg.dl0_cfg;
  assign bus_grant4_cfg_out = state_reg.bus_grant4_strap_cfg;
  assign mem_mult_x2_out = state_reg.ratio.mem_x2;
  assign cpu_mult_x2_out = state_reg.ratio.cpu_x2;
  assign cpu_multiplier_readback_out = state_reg.ratio.readback;
  assign bypass_out = state_reg.ratio.bypass;
  assign clock_off_out = state_reg.ratio.clk_off;
  assign invalid_out = state_reg.ratio.invalid;
  assign mem_clk_en_out = state_reg.mem_clk_en;
  assign mem_pll_en_out = state_reg.mem_pll_en;
  assign cpu_clk_en_out = state_reg.cpu_clk_en;
  assign cpu_src_ref_out = state_reg.cpu_src_ref;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_strap_held_stable: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    state_reg.captured |=> $stable(strap_cfg_out) && cfg_valid_out)
    else $error("strap changed after capture");

  a_pullup_until_capture: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    pullup_en_out == !cfg_valid_out)
    else $error("pull-up enable wrong for capture state");

  a_strap_sampled_pins: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in)
    $rose(cfg_valid_out) |-> low_data_bit0_cfg_out == $past(low_data_bit0_strap_in)
      && bus_grant4_cfg_out == $past(bus_grant4_strap_in)
      && strap_cfg_out == $past(strap_cfg_in))
    else $error("strap pins not sampled on capture");

  a_decode_code_zero: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in)
    cfg_valid_out && strap_cfg_out == 5'h00 |-> mem_mult_x2_out == 4'h6
      && cpu_mult_x2_out == 4'h5 && cpu_clk_en_out)
    else $error("code 00000 decoded wrongly");

  a_readback_by_ratio: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in)
    cfg_valid_out && !invalid_out && cpu_mult_x2_out == 4'h6
      |-> cpu_multiplier_readback_out == 5'h18)
    else $error("readback not tied to processor ratio");

  a_bypass_codes_sel: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    cfg_valid_out && strap_cfg_out inside {5'h03, 5'h05, 5'h07}
      |-> bypass_out && cpu_clk_en_out
      && cpu_mult_x2_out == ((strap_cfg_out == 5'h03) ? 4'h4 :
                             (strap_cfg_out == 5'h05) ? 4'h5 : 4'h6))
    else $error("bypass code not in bypass");

  a_bypass_ratio_one: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    bypass_out && cfg_valid_out |-> mem_mult_x2_out == 4'h2 && !mem_pll_en_out
      && cpu_src_ref_out)
    else $error("bypass does not force one to one");

  a_clock_off_gate: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    cfg_valid_out && strap_cfg_out[4:1] == 4'hF |-> clock_off_out && !cpu_clk_en_out
      && !mem_clk_en_out && !mem_pll_en_out)
    else $error("clock-off code still clocks");

  a_invalid_no_clk: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    invalid_out || !cfg_valid_out |-> !cpu_clk_en_out && !mem_clk_en_out)
    else $error("invalid code enables clocks");

  a_open_drain_mode: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    power_mgmt_control_two_od_in |=> !(od_pin_oe_out && od_pin_out)
      && od_pin_oe_out == !$past(od_pin_data_in))
    else $error("open-drain pin drives high");

  a_stri_park_high: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    state_reg.stri_st == psrd_pkg::STRI_DRIVE && !stri_drive_in
      |=> stri_pin_oe_out && stri_pin_out ##1 !stri_pin_oe_out)
    else $error("sustained pin not parked high");

  c_bypass_seen: cover property (@(posedge core_clk_in) disable iff (!reset_n_in)
    cfg_valid_out && bypass_out && cpu_clk_en_out);

  c_clock_off_seen: cover property (@(posedge core_clk_in) disable iff (!reset_n_in)
    cfg_valid_out && clock_off_out);

  c_normal_run: cover property (@(posedge core_clk_in) disable iff (!reset_n_in)
    cfg_valid_out && mem_pll_en_out && cpu_clk_en_out);

  c_stri_release: cover property (@(posedge core_clk_in) disable iff (!reset_n_in)
    stri_pin_oe_out && stri_pin_out ##1 !stri_pin_oe_out);

endmodule // psrd_top
